//--- core/ctx_ram_pkg.sv
// constants and types shared by the context memory and engine clock logic
// How it works
// - each half-duplex channel keeps its own context
// - static mode: direct address, 2 Mbytes maximum
// - dynamic memory means EDO sequencing only
// - dram: address 11..0 row/column, 12 is RAS
// - dram: 13/14 column strobes, 15 WE, 16 OE
// - dram space limited to 32 Mbytes
// - config bit picks static or dynamic timing
// - first algorithm: one 16K block, full duplex
// - MPPC: 16K per direction, separate sessions
// - one compression context plus encryption contexts
// - extra encryption contexts take 128 or 512 bytes
// - bus clock, processing clock, derived engine clock
// - engine clock from selected source, drives port
// - pll bypassed: engine clock is a quarter of the input
// - pll enabled: engine clock is input halved
// - config holds type, dram size, refresh rate
package ctx_ram_pkg;
  // register bus
  localparam int REG_ADDR_W = 4;
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // configuration field positions
  localparam int CFG_DRAM = 0;
  localparam int CFG_SIZE_LO = 1;
  localparam int CFG_RATE_LO = 3;
  localparam int CFG_MPPC = 6;
  localparam int CFG_ENC_LARGE = 7;
  // status field positions
  localparam int STS_BUSY = 0;
  localparam int STS_REF_PEND = 1;
  localparam int STS_REF_CNT_LO = 8;
  // context memory geometry, 16-bit words
  localparam int WORD_ADDR_W = 24;
  localparam int SRAM_ADDR_W = 20;
  localparam int DRAM_MIN_W = 21;
  localparam int COL_W = 12;
  localparam int PIN_W = 21;
  localparam int PIN_RAS = 12;
  localparam int PIN_LCOL = 13;
  localparam int PIN_UCOL = 14;
  localparam int PIN_WE = 15;
  localparam int PIN_OE = 16;
  localparam int SESSION_W = 8;
  localparam int OFFSET_W = 14;
  localparam int BLOCK_WORDS_LOG2 = 13;
  localparam int ENC_SMALL_LOG2 = 6;
  localparam int ENC_LARGE_LOG2 = 8;
  // timing, figures in ns; engine ticks are at least two clocks apart
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_NS = 2 * CLK_PERIOD_NS;
  localparam int SRAM_ACCESS_NS = 12;
  localparam int DRAM_ACCESS_NS = 60;
  localparam int DRAM_PRECHARGE_NS = 40;
  localparam int SRAM_TICKS =
    (SRAM_ACCESS_NS + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS;
  localparam int DRAM_TICKS =
    (DRAM_ACCESS_NS + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS;
  localparam int PRE_TICKS =
    (DRAM_PRECHARGE_NS + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS;
  localparam int REFRESH_BASE_TICKS = 16;
  localparam int CNT_W = 4;
  localparam int REF_TIMER_W = 8;

  typedef struct packed {
    logic write;
    logic [SESSION_W-1:0] session;
    logic [OFFSET_W-1:0] offset;
    logic [15:0] wdata;
  } ctx_req_type;

  typedef struct packed {
    logic [REG_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic write;
    logic read;
  } reg_bus_type;
endpackage

//--- core/engine_clock_gen.sv
// engine clock source selection, synchronisers and optional halving
`timescale 1ns/1ns
`default_nettype none
module engine_clock_gen
  import ctx_ram_pkg::*;
(
  // system
  input wire logic sys_clk,
  input wire logic rst_n,
  // clock sources and straps
  input wire logic proc_clk_in,
  input wire logic bus_clk_in,
  input wire logic clk_source_select,
  input wire logic pll_enable_n,
  // engine timing
  output logic engine_clk,
  output logic engine_tick
);
  logic [1:0] proc_sync;
  logic [1:0] bus_sync;
  logic src_last;
  logic half_phase;
  wire src_level = clk_source_select ? proc_sync[1] : bus_sync[1];
  wire src_rise = src_level & ~src_last;
  // bypassed pll: only every second source edge makes a tick
  wire next_tick = src_rise & (~pll_enable_n | half_phase);

  // unrelated clocks are only looked at after two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      proc_sync <= 2'h0;
      bus_sync <= 2'h0;
      src_last <= 1'b0;
    end else begin
      proc_sync <= {proc_sync[0], proc_clk_in};
      bus_sync <= {bus_sync[0], bus_clk_in};
      src_last <= src_level;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_phase <= 1'b0;
      engine_tick <= 1'b0;
      engine_clk <= 1'b0;
    end else begin
      if (src_rise) half_phase <= ~half_phase;
      engine_tick <= next_tick;
      if (next_tick) engine_clk <= ~engine_clk;
    end
  end

  AST_TICK_FROM_EDGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    engine_tick |-> $past(src_rise))
    else $error("engine tick without a source edge");
  AST_HALF_RATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pll_enable_n && $past(pll_enable_n) && engine_tick)
      |-> $past(half_phase))
    else $error("bypassed pll ticked on the wrong source edge");
endmodule
`default_nettype wire

//--- core/context_ram_clock_ctrl.sv
// context memory port for static or edo dynamic ram, with refresh
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module context_ram_clock_ctrl
  import ctx_ram_pkg::*;
#(
  parameter int REFRESH_BASE = REFRESH_BASE_TICKS
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // clock sources
  input wire logic proc_clk_in,
  input wire logic bus_clk_in,
  input wire logic clk_source_select,
  input wire logic pll_enable_n,
  output logic engine_clk,
  // register port
  input wire reg_bus_type reg_bus,
  output logic [31:0] reg_rdata,
  // context requests from the engines
  input wire logic req_valid,
  input wire ctx_req_type req,
  output logic req_ready,
  output logic resp_valid,
  output logic [15:0] resp_rdata,
  // context memory pins
  output logic [PIN_W-1:0] context_addr,
  output logic sram_ce_n,
  output logic sram_we_n,
  output logic sram_oe_n,
  input wire logic [15:0] mem_dq_in,
  output logic [15:0] mem_dq_out,
  output logic mem_dq_oe
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_SRAM, ST_ROW, ST_COL, ST_PRE, ST_REF_CAS, ST_REF_RAS
  } port_state_type;

  logic [1:0] rst_pipe;
  wire rst_sync = rst_pipe[1];
  logic engine_tick;
  logic [7:0] cfg;
  port_state_type state;
  port_state_type next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic cur_write;
  logic [WORD_ADDR_W-1:0] cur_addr;
  logic [15:0] cur_wdata;
  logic [REF_TIMER_W-1:0] ref_timer;
  logic refresh_pending;
  logic [7:0] refresh_count;

  // reset is released through two flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) rst_pipe <= 2'h0;
    else rst_pipe <= {rst_pipe[0], 1'b1};
  end

  engine_clock_gen u_clk (
    .sys_clk(sys_clk),
    .rst_n(rst_sync),
    .proc_clk_in(proc_clk_in),
    .bus_clk_in(bus_clk_in),
    .clk_source_select(clk_source_select),
    .pll_enable_n(pll_enable_n),
    .engine_clk(engine_clk),
    .engine_tick(engine_tick)
  );

  // configuration fields
  wire cfg_dram = cfg[CFG_DRAM];
  wire [1:0] cfg_size = cfg[CFG_SIZE_LO +: 2];
  wire [2:0] cfg_rate = cfg[CFG_RATE_LO +: 3];
  wire cfg_mppc = cfg[CFG_MPPC];
  wire cfg_enc_large = cfg[CFG_ENC_LARGE];

  // session layout: compression blocks first, encryption contexts after
  function automatic logic [WORD_ADDR_W-1:0] ctx_word_addr(
    input ctx_req_type r, input logic mppc, input logic enc_large);
    logic [WORD_ADDR_W-1:0] comp_sessions;
    logic [WORD_ADDR_W-1:0] sess;
    logic [WORD_ADDR_W-1:0] word_off;
    logic [WORD_ADDR_W-1:0] enc_base;
    comp_sessions = mppc ? 24'h000002 : 24'h000001;
    sess = {{(WORD_ADDR_W-SESSION_W){1'b0}}, r.session};
    word_off = {{(WORD_ADDR_W-OFFSET_W+1){1'b0}}, r.offset[OFFSET_W-1:1]};
    enc_base = comp_sessions << BLOCK_WORDS_LOG2;
    if (sess < comp_sessions) begin
      ctx_word_addr = (sess << BLOCK_WORDS_LOG2) + word_off;
    end else if (enc_large) begin
      ctx_word_addr = enc_base + ((sess - comp_sessions) << ENC_LARGE_LOG2)
        + (word_off & 24'h0000ff);
    end else begin
      ctx_word_addr = enc_base + ((sess - comp_sessions) << ENC_SMALL_LOG2)
        + (word_off & 24'h00003f);
    end
  endfunction

  // addresses wrap inside the memory that is fitted
  function automatic logic [WORD_ADDR_W-1:0] size_limit(
    input logic [WORD_ADDR_W-1:0] a, input logic dram, input logic [1:0] sz);
    logic [WORD_ADDR_W-1:0] mask;
    mask = 24'h000000;
    if (!dram) mask = 24'h0fffff;
    else mask = (24'h200000 << sz) - 24'h000001;
    size_limit = a & mask;
  endfunction

  // memory pin pattern for a given state
  function automatic logic [PIN_W-1:0] pins_for(input port_state_type s,
    input logic dram, input logic wr, input logic [WORD_ADDR_W-1:0] a);
    logic [PIN_W-1:0] p;
    p = '0;
    if (!dram) begin
      if (s == ST_SRAM) p = {1'b0, a[SRAM_ADDR_W-1:0]};
    end else begin
      p[PIN_OE:PIN_RAS] = 5'h1f; // strobes idle high
      unique case (s)
        ST_ROW: begin
          p[COL_W-1:0] = a[WORD_ADDR_W-1:COL_W];
          p[PIN_RAS] = 1'b0;
        end
        ST_COL: begin
          p[COL_W-1:0] = a[COL_W-1:0];
          p[PIN_RAS] = 1'b0;
          p[PIN_LCOL] = 1'b0;
          p[PIN_UCOL] = 1'b0;
          p[PIN_WE] = ~wr;
          p[PIN_OE] = wr;
        end
        ST_REF_CAS: begin
          p[PIN_LCOL] = 1'b0;
          p[PIN_UCOL] = 1'b0;
        end
        ST_REF_RAS: begin
          p[PIN_RAS] = 1'b0;
          p[PIN_LCOL] = 1'b0;
          p[PIN_UCOL] = 1'b0;
        end
        default: p[PIN_OE:PIN_RAS] = 5'h1f;
      endcase
    end
    pins_for = p;
  endfunction

  // refresh wins the idle slot so accesses never starve it
  assign req_ready = (state == ST_IDLE) && engine_tick
    && !refresh_pending;
  wire take_req = req_valid && req_ready;
  wire step = engine_tick && (cnt == '0);
  wire [WORD_ADDR_W-1:0] new_addr =
    size_limit(ctx_word_addr(req, cfg_mppc, cfg_enc_large), cfg_dram, cfg_size);
  wire [REF_TIMER_W-1:0] ref_interval =
    REF_TIMER_W'(REFRESH_BASE) * ({5'h00, cfg_rate} + 8'h01);
  wire ref_expire = cfg_dram && engine_tick && (ref_timer == '0);
  wire ref_start = (state == ST_IDLE) && engine_tick && refresh_pending;
  wire access_done = step && ((state == ST_SRAM) || (state == ST_COL));

  // sequencer; dwell counts come from the memory type in use
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (engine_tick && cnt != '0) begin
      next_cnt = cnt - CNT_W'(1);
    end else if (engine_tick) begin
      unique case (state)
        ST_IDLE: begin
          if (ref_start) begin
            next_state = ST_REF_CAS;
            next_cnt = CNT_W'(DRAM_TICKS - 1);
          end else if (take_req && !cfg_dram) begin
            next_state = ST_SRAM;
            next_cnt = CNT_W'(SRAM_TICKS - 1);
          end else if (take_req) begin
            next_state = ST_ROW;
            next_cnt = CNT_W'(DRAM_TICKS - 1);
          end
        end
        ST_SRAM: next_state = ST_IDLE;
        ST_ROW: begin
          next_state = ST_COL;
          next_cnt = CNT_W'(DRAM_TICKS - 1);
        end
        ST_COL: begin
          next_state = ST_PRE;
          next_cnt = CNT_W'(PRE_TICKS - 1);
        end
        ST_PRE: next_state = ST_IDLE;
        ST_REF_CAS: begin
          next_state = ST_REF_RAS;
          next_cnt = CNT_W'(DRAM_TICKS - 1);
        end
        ST_REF_RAS: begin
          next_state = ST_PRE;
          next_cnt = CNT_W'(PRE_TICKS - 1);
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= ST_IDLE;
      cnt <= '0;
      cur_write <= 1'b0;
      cur_addr <= '0;
      cur_wdata <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      if (take_req) begin
        cur_write <= req.write;
        cur_addr <= new_addr;
        cur_wdata <= req.wdata;
      end
    end
  end

  // pins are registered from the next state so they change with it
  wire next_write = take_req ? req.write : cur_write;
  wire [WORD_ADDR_W-1:0] next_addr = take_req ? new_addr : cur_addr;
  wire next_drive = next_write
    && (next_state == ST_SRAM || next_state == ST_COL);
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      context_addr <= '0;
      sram_ce_n <= 1'b1;
      sram_we_n <= 1'b1;
      sram_oe_n <= 1'b1;
      mem_dq_out <= 16'h0000;
      mem_dq_oe <= 1'b0;
    end else begin
      context_addr <= pins_for(next_state, cfg_dram, next_write, next_addr);
      sram_ce_n <= ~(next_state == ST_SRAM);
      sram_we_n <= ~(next_state == ST_SRAM && next_write);
      sram_oe_n <= ~(next_state == ST_SRAM && !next_write);
      mem_dq_out <= take_req ? req.wdata : cur_wdata;
      mem_dq_oe <= next_drive;
    end
  end

  // read data is caught on the last tick of the access
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      resp_valid <= 1'b0;
      resp_rdata <= 16'h0000;
    end else begin
      resp_valid <= access_done;
      if (access_done && !cur_write) resp_rdata <= mem_dq_in;
    end
  end

  // refresh timer; a new expiry beats the clear of the pending flag
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      ref_timer <= '0;
      refresh_pending <= 1'b0;
      refresh_count <= 8'h00;
    end else begin
      if (!cfg_dram) ref_timer <= ref_interval;
      else if (engine_tick) ref_timer <= ref_expire ? ref_interval
        : ref_timer - REF_TIMER_W'(1);
      if (ref_expire) refresh_pending <= 1'b1;
      else if (ref_start) refresh_pending <= 1'b0;
      if (ref_start) refresh_count <= refresh_count + 8'h01;
    end
  end

  // register port, read data the cycle after the strobe
  wire [31:0] status_word = {16'h0000, refresh_count, 6'h00,
    refresh_pending, state != ST_IDLE};
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      cfg <= CFG_RESET;
      reg_rdata <= 32'h00000000;
    end else begin
      if (reg_bus.write && reg_bus.addr == REG_CONFIG)
        cfg <= reg_bus.wdata[7:0];
      if (!reg_bus.read) reg_rdata <= 32'h00000000;
      else if (reg_bus.addr == REG_CONFIG) reg_rdata <= {24'h000000, cfg};
      else if (reg_bus.addr == REG_STATUS) reg_rdata <= status_word;
      else reg_rdata <= 32'h00000000;
    end
  end

  sequence s_col_done;
    state == ST_COL && engine_tick && cnt == '0;
  endsequence
  sequence s_row_open;
    state == ST_ROW && !context_addr[PIN_RAS] && context_addr[PIN_LCOL];
  endsequence

  AST_READY_NO_REFRESH: assert property (@(posedge sys_clk)
    disable iff (!rst_sync)
    (state == ST_IDLE && engine_tick && refresh_pending)
      |-> !req_ready ##1 state == ST_REF_CAS)
    else $error("access offered while a refresh is owed");
  AST_ROW_STROBE: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    (state == ST_ROW && cfg_dram) |-> s_row_open)
    else $error("row phase without RAS low and CAS high");
  AST_COL_STROBES: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    (state == ST_COL && cfg_dram) |-> !context_addr[PIN_LCOL]
      && !context_addr[PIN_UCOL] && context_addr[PIN_WE] == !cur_write
      && context_addr[PIN_OE] == cur_write)
    else $error("column phase strobes wrong");
  AST_COL_TO_PRE: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    s_col_done |=> state == ST_PRE ##0 resp_valid)
    else $error("column access did not close into precharge");
  AST_SRAM_SELECT: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    (state == ST_SRAM) == !sram_ce_n)
    else $error("static select does not follow the access");
  AST_TYPE_PATH: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    (take_req && $stable(cfg_dram)) |=>
      (cfg_dram ? state == ST_ROW : state == ST_SRAM))
    else $error("access path does not follow memory type");
  AST_CBR_ORDER: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    $rose(state == ST_REF_RAS) |-> $past(state) == ST_REF_CAS)
    else $error("refresh RAS without CAS first");
  AST_DRAM_WIDTH: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    (state == ST_ROW) |-> {1'b0, cur_addr} < (25'h200000 << cfg_size))
    else $error("dram address beyond fitted size");
  AST_RESP_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_sync)
    resp_valid |=> !resp_valid)
    else $error("response longer than one cycle");
endmodule
`default_nettype wire

//--- bench/ctx_mem_model.sv
// behavioural context memory: static ram or edo dynamic ram
`timescale 1ns/1ns
`default_nettype none
module ctx_mem_model (
  // clock and mode
  input wire logic sys_clk,
  input wire logic dram_mode,
  // memory pins
  input wire logic [20:0] context_addr,
  input wire logic sram_ce_n,
  input wire logic sram_we_n,
  input wire logic sram_oe_n,
  input wire logic [15:0] mem_dq_out,
  input wire logic mem_dq_oe,
  output logic [15:0] mem_dq_in
);
  logic [15:0] mem [logic [23:0]];
  logic [11:0] row = 12'h000;
  logic [15:0] last = 16'h0000;
  logic [15:0] cur;
  logic ras_q = 1'b1;
  // strobes borrowed from the upper address pins in dram mode
  wire logic ras_n = context_addr[12];
  wire logic lower_col_strobe_n = context_addr[13];
  wire logic upper_col_strobe_n = context_addr[14];
  wire logic we_n = context_addr[15];
  wire logic oe_n = context_addr[16];
  // 24-bit word key covers the largest dynamic part
  wire logic [23:0] key = dram_mode ? {row, context_addr[11:0]} :
    {4'h0, context_addr[19:0]};
  // edo keeps data out while output enable and RAS both stay low
  wire logic drive = dram_mode ? (!oe_n && !ras_n) :
    (!sram_ce_n && !sram_oe_n);
  function automatic logic [15:0] rd(input logic [23:0] k);
    return mem.exists(k) ? mem[k] : 16'h0000;
  endfunction
  // released bus shows the inverse, so stale data cannot pass
  assign mem_dq_in = drive ? rd(key) : ~last;
  // row latched on the strobe fall; byte lanes follow the column strobes
  always @(posedge sys_clk) begin
    ras_q <= ras_n;
    cur = rd(key);
    if (drive) last <= cur;
    if (dram_mode && ras_q && !ras_n) row <= context_addr[11:0];
    if (dram_mode && !ras_n && !we_n && mem_dq_oe &&
        (!lower_col_strobe_n || !upper_col_strobe_n)) begin
      mem[key] = {upper_col_strobe_n ? cur[15:8] : mem_dq_out[15:8],
        lower_col_strobe_n ? cur[7:0] : mem_dq_out[7:0]};
    end
    if (!dram_mode && !sram_ce_n && !sram_we_n && mem_dq_oe) begin
      mem[key] = mem_dq_out;
    end
  end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the context memory port and engine clock
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin \
  err_count++; $display("BAD %0t %s", $time, m); end end
module tb_top;
  import ctx_ram_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic proc_clk_in = 1'b0;
  logic bus_clk_in = 1'b0;
  logic clk_source_select = 1'b1;
  logic pll_enable_n = 1'b0;
  logic engine_clk;
  reg_bus_type reg_bus = '0;
  logic [31:0] reg_rdata;
  logic req_valid = 1'b0;
  ctx_req_type req = '0;
  logic req_ready, resp_valid, sram_ce_n, sram_we_n, sram_oe_n, mem_dq_oe;
  logic [15:0] resp_rdata, mem_dq_in, mem_dq_out;
  logic [20:0] context_addr, seen_addr;
  logic src_run = 1'b1;
  logic dram_sel = 1'b0;
  logic bad_pins;
  int err_count = 0;
  int comparisons = 0;
  int toggles = 0;
  int lat, lat_static;

  context_ram_clock_ctrl #(.REFRESH_BASE(2)) uut (.sys_clk(sys_clk),
    .reset_n(reset_n), .proc_clk_in(proc_clk_in), .bus_clk_in(bus_clk_in),
    .clk_source_select(clk_source_select), .pll_enable_n(pll_enable_n),
    .engine_clk(engine_clk), .reg_bus(reg_bus), .reg_rdata(reg_rdata),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .context_addr(context_addr), .sram_ce_n(sram_ce_n),
    .sram_we_n(sram_we_n), .sram_oe_n(sram_oe_n), .mem_dq_in(mem_dq_in),
    .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));
  ctx_mem_model mem (.sys_clk(sys_clk), .dram_mode(dram_sel),
    .context_addr(context_addr), .sram_ce_n(sram_ce_n),
    .sram_we_n(sram_we_n), .sram_oe_n(sram_oe_n),
    .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in));

  // 100 ns system clock
  initial forever #50 sys_clk = ~sys_clk;
  // processing clock at a quarter of the system rate while running
  initial forever begin
    repeat (2) @(posedge sys_clk);
    if (src_run) proc_clk_in <= ~proc_clk_in;
  end
  // every engine clock edge is one tick
  always @(engine_clk) toggles++;

  task automatic print_verdict;
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_bus <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge sys_clk);
    reg_bus <= '0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_bus <= '{addr: a, wdata: 32'h0, write: 1'b0, read: 1'b1};
    @(posedge sys_clk);
    reg_bus <= '0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  // one context access; records the first address put on the pins
  task automatic ctx_op(input logic w, input logic [7:0] s,
      input logic [13:0] off, input logic [15:0] wd, output logic [15:0] rd);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge sys_clk);
    req <= '{write: w, session: s, offset: off, wdata: wd};
    req_valid <= 1'b1;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && n < 200) begin
      n++;
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    req_valid <= 1'b0;
    lat = 0;
    @(negedge sys_clk);
    while (resp_valid !== 1'b1 && lat < 200) begin
      if (!got && (sram_ce_n === 1'b0 || context_addr[12] === 1'b0)) begin
        got = 1'b1;
        seen_addr = context_addr;
      end
      if (dram_sel && !context_addr[13] && context_addr[12]) bad_pins = 1;
      if (dram_sel && context_addr[20:17] !== 4'h0) bad_pins = 1;
      lat++;
      @(negedge sys_clk);
    end
    rd = resp_rdata;
    `CHK(n < 200 && lat < 200, 1'b1, "access hung")
  endtask

  task automatic t_regs;
    logic [31:0] d;
    reg_rd(REG_CONFIG, d);
    `CHK(d, 32'h0, "config reset")
    reg_wr(REG_STATUS, 32'hffff_ffff);
    reg_rd(REG_STATUS, d);
    `CHK(d, 32'h0, "status idle")
    reg_wr(4'h8, 32'h1234_5678);
    reg_rd(4'h8, d);
    `CHK(d, 32'h0, "unmapped read")
    reg_wr(REG_CONFIG, 32'hffff_ffff);
    reg_rd(REG_CONFIG, d);
    `CHK(d, 32'h0000_00ff, "config bits")
    reg_wr(REG_CONFIG, 32'h0);
  endtask

  // session placement for each layout choice
  task automatic t_layout;
    logic [7:0] cf [5] = '{8'h00, 8'h00, 8'h40, 8'h40, 8'h80};
    logic [7:0] ss [5] = '{8'h00, 8'h02, 8'h01, 8'h03, 8'h03};
    logic [13:0] of [5] = '{14'h3ffe, 14'h0004, 14'h0002, 14'h0006, 14'h01fe};
    logic [15:0] r;
    int nc, sz, ex;
    for (int i = 0; i < 5; i++) begin
      reg_wr(REG_CONFIG, {24'h0, cf[i]});
      nc = cf[i][6] ? 2 : 1;
      sz = cf[i][7] ? 256 : 64;
      ex = (ss[i] < nc) ? ss[i] * 8192 : nc * 8192 + (ss[i] - nc) * sz;
      ex = ex + of[i] / 2;
      ctx_op(1'b1, ss[i], of[i], 16'ha5c0 + 16'(i), r);
      `CHK(seen_addr, 21'(ex), "context address")
      lat_static = lat;
      ctx_op(1'b0, ss[i], of[i], 16'h0, r);
      `CHK(r, 16'ha5c0 + 16'(i), "static read back")
    end
    reg_wr(REG_CONFIG, 32'h0);
  endtask

  task automatic t_dram;
    logic [15:0] r;
    logic [31:0] d;
    bad_pins = 1'b0;
    reg_wr(REG_CONFIG, 32'h39);
    dram_sel = 1'b1;
    ctx_op(1'b1, 8'h00, 14'h0010, 16'h3c5a, r);
    `CHK(lat > lat_static, 1'b1, "dram slower")
    ctx_op(1'b1, 8'h02, 14'h0010, 16'hc3a5, r);
    ctx_op(1'b0, 8'h00, 14'h0010, 16'h0, r);
    `CHK(r, 16'h3c5a, "dram read a")
    repeat (300) @(posedge sys_clk);
    reg_rd(REG_STATUS, d);
    `CHK(d[15:8] != 8'h00, 1'b1, "refresh count")
    ctx_op(1'b0, 8'h02, 14'h0010, 16'h0, r);
    `CHK(r, 16'hc3a5, "dram read after refresh")
    `CHK(bad_pins, 1'b0, "strobe pins")
    reg_wr(REG_CONFIG, 32'h0);
    dram_sel = 1'b0;
  endtask

  // engine clock edges over eight rises of a source, selected or not
  task automatic t_clock;
    logic [1:0] cs [5] = '{2'b10, 2'b11, 2'b00, 2'b00, 2'b01};
    logic px [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    int ex [5] = '{8, 4, 0, 8, 4};
    int base;
    src_run = 1'b0;
    @(posedge sys_clk);
    proc_clk_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      clk_source_select <= cs[i][1];
      pll_enable_n <= cs[i][0];
      repeat (10) @(posedge sys_clk);
      base = toggles;
      repeat (8) begin
        repeat (3) @(posedge sys_clk);
        if (px[i]) proc_clk_in <= 1'b1;
        else bus_clk_in <= 1'b1;
        repeat (3) @(posedge sys_clk);
        if (px[i]) proc_clk_in <= 1'b0;
        else bus_clk_in <= 1'b0;
      end
      repeat (8) @(posedge sys_clk);
      `CHK(toggles - base, ex[i], "engine clock rate")
    end
    @(posedge sys_clk);
    clk_source_select <= 1'b1;
    pll_enable_n <= 1'b0;
    src_run = 1'b1;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_regs;
    t_layout;
    t_dram;
    t_clock;
    print_verdict;
  end

  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    print_verdict;
  end
endmodule
`default_nettype wire
